// File: hw/analog_measurement_code_scaler.sv
// Top: AHB-Lite registers, per-channel config, result store, interrupt
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module analog_measurement_code_scaler (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_smp_valid,
   input wire logic [2:0] i_smp_chan,
   input wire logic [31:0] i_smp_raw,
   output logic o_code_valid,
   output logic [2:0] o_code_chan,
   output logic [15:0] o_code,
   output logic o_irq
);
   localparam logic [2:0] LAST_CH = 3'(code_scaler_pkg::N_CH - 1);
   localparam logic [1:0] HSIZE_WORD = 2'h2;

   // Register kinds behind the low address byte
   typedef enum logic [2:0] {
      REG_NONE,
      REG_CFG,
      REG_RES,
      REG_STS,
      REG_MSK
   } reg_kind_e;

   logic [code_scaler_pkg::CFG_W-1:0] cfg_ff [code_scaler_pkg::N_CH];
   logic [15:0] res_ff [code_scaler_pkg::N_CH];
   logic [code_scaler_pkg::EVT_W-1:0] sts_ff;
   logic [code_scaler_pkg::EVT_W-1:0] msk_ff;
   logic [code_scaler_pkg::EVT_W-1:0] evt;
   logic [code_scaler_pkg::EVT_W-1:0] sts_clr;
   logic [code_scaler_pkg::EVT_W-1:0] nxt_sts;
   reg_kind_e wr_kind_ff;
   logic [code_scaler_pkg::N_CH-1:0] cfg_we;
   logic [code_scaler_pkg::N_CH-1:0] res_we;
   logic [7:0] wr_addr_ff;
   logic [31:0] hrdata_ff;
   logic [31:0] rd_word;
   logic addr_ph;
   logic smp_ok;
   logic [code_scaler_pkg::CFG_W-1:0] smp_cfg;
   logic code_valid_ff;
   logic [2:0] code_chan_ff;
   logic [15:0] code_ff;

   scale_if sif ();

   // Byte offset to channel index when the address hits a channel slot
   function automatic logic chan_hit(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      return (a >= base) && (d[1:0] == 2'b00) && (d[7:2] <= 6'(LAST_CH));
   endfunction

   function automatic logic [2:0] chan_idx(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      return d[4:2];
   endfunction

   // Which register an address names; read and write side share it
   function automatic reg_kind_e reg_kind(input logic [31:0] a);
      reg_kind_e k;
      k = REG_NONE;
      if (a[31:8] == 24'h00_0000) begin
         if (chan_hit(a[7:0], code_scaler_pkg::OFS_CFG)) begin
            k = REG_CFG;
         end else if (chan_hit(a[7:0], code_scaler_pkg::OFS_RES)) begin
            k = REG_RES;
         end else if (a[7:0] == code_scaler_pkg::OFS_STS) begin
            k = REG_STS;
         end else if (a[7:0] == code_scaler_pkg::OFS_MSK) begin
            k = REG_MSK;
         end
      end
      return k;
   endfunction

   // Scaler and limiter share the bundle
   code_scaler_core u_scaler (
      .s(sif.scl_mp)
   );

   code_limiter u_limiter (
      .s(sif.lim_mp)
   );

   // Sample path: channel picks its own config; out-of-range index dropped
   always_comb begin
      smp_ok = i_smp_valid && (i_smp_chan <= LAST_CH);
      smp_cfg = (i_smp_chan <= LAST_CH) ? cfg_ff[i_smp_chan] : '0;
   end

   assign sif.raw = i_smp_raw;
   assign sif.rng = smp_cfg[code_scaler_pkg::CFG_RNG_LSB +: 4];
   assign sif.unit = smp_cfg[code_scaler_pkg::CFG_UNIT_LSB +: 2];

   // One-hot enables per channel: a config write lands, a sample lands
   always_comb begin
      cfg_we = '0;
      res_we = '0;
      for (int i = 0; i < code_scaler_pkg::N_CH; i++) begin
         cfg_we[i] = (wr_kind_ff == REG_CFG) &&
                     (chan_idx(wr_addr_ff, code_scaler_pkg::OFS_CFG) == 3'(i));
         res_we[i] = smp_ok && (i_smp_chan == 3'(i));
      end
   end

   // Per-channel config and result; the last channel wakes up as a thermometer
   for (genvar c = 0; c < code_scaler_pkg::N_CH; c++) begin : g_chan
      localparam logic [code_scaler_pkg::CFG_W-1:0] CFG_RST =
         (c == code_scaler_pkg::N_CH - 1) ? code_scaler_pkg::CFG_RST_PT :
         code_scaler_pkg::CFG_RST_AI;

      // A new setting applies from the next sample on
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            cfg_ff[c] <= CFG_RST;
         end else if (cfg_we[c]) begin
            cfg_ff[c] <= i_hwdata[code_scaler_pkg::CFG_W-1:0];
         end
      end

      // Result holds until the next sample of this channel
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            res_ff[c] <= code_scaler_pkg::RES_RST;
         end else if (res_we[c]) begin
            res_ff[c] <= sif.code;
         end
      end
   end

   // Streamed copy of the newest result for the process image
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         code_valid_ff <= 1'b0;
         code_chan_ff <= '0;
         code_ff <= code_scaler_pkg::RES_RST;
      end else begin
         code_valid_ff <= smp_ok;
         if (smp_ok) begin
            code_chan_ff <= i_smp_chan;
            code_ff <= sif.code;
         end
      end
   end

   assign o_code_valid = code_valid_ff;
   assign o_code_chan = code_chan_ff;
   assign o_code = code_ff;

   // AHB-Lite address phase: zero wait states, always OKAY
   assign addr_ph = i_hsel && i_htrans[1] && i_hready;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // Only aligned word writes in the low 256 bytes take effect
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_kind_ff <= REG_NONE;
         wr_addr_ff <= '0;
      end else begin
         wr_kind_ff <= REG_NONE;
         if (addr_ph && i_hwrite && (i_hsize[1:0] == HSIZE_WORD)) begin
            wr_kind_ff <= reg_kind(i_haddr);
         end
         if (addr_ph) begin
            wr_addr_ff <= i_haddr[7:0];
         end
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (reg_kind(i_haddr))
         REG_CFG: begin
            rd_word[code_scaler_pkg::CFG_W-1:0] =
               cfg_ff[chan_idx(i_haddr[7:0], code_scaler_pkg::OFS_CFG)];
         end
         REG_RES: begin
            rd_word[15:0] = res_ff[chan_idx(i_haddr[7:0], code_scaler_pkg::OFS_RES)];
         end
         REG_STS: begin
            rd_word[code_scaler_pkg::EVT_W-1:0] = sts_ff;
         end
         REG_MSK: begin
            rd_word[code_scaler_pkg::EVT_W-1:0] = msk_ff;
         end
         REG_NONE: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured in the address phase so it comes from a flop
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (addr_ph && !i_hwrite) begin
         hrdata_ff <= rd_word;
      end
   end

   assign o_hrdata = hrdata_ff;

   // Mask register, same layout as status
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         msk_ff <= '0;
      end else if (wr_kind_ff == REG_MSK) begin
         msk_ff <= i_hwdata[code_scaler_pkg::EVT_W-1:0];
      end
   end

   // Events from the sample just scaled
   always_comb begin
      evt = '0;
      evt[code_scaler_pkg::EVT_NEW] = smp_ok;
      evt[code_scaler_pkg::EVT_OVF] = smp_ok && sif.ovf;
      evt[code_scaler_pkg::EVT_UNF] = smp_ok && sif.unf;
      evt[code_scaler_pkg::EVT_CFG] = smp_ok && sif.cfg_err;
      sts_clr = '0;
      if (wr_kind_ff == REG_STS) begin
         sts_clr = i_hwdata[code_scaler_pkg::EVT_W-1:0];
      end
      // Set wins so an event in the clearing cycle is not lost
      nxt_sts = (sts_ff & ~sts_clr) | evt;
   end

   // Sticky status, write one to clear
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sts_ff <= '0;
      end else begin
         sts_ff <= nxt_sts;
      end
   end

   // Level interrupt while any unmasked status bit is set
   assign o_irq = |(sts_ff & msk_ff);

endmodule
`default_nettype wire

// File: hw/code_limiter.sv
// Region check and saturation of the scaled value to a 16-bit code
`timescale 1ns/10ps
`default_nettype none
module code_limiter (
   scale_if.lim_mp s
);
   // Config error wins over any measured value
   always_comb begin
      s.ovf = 1'b0;
      s.unf = 1'b0;
      if (s.cfg_err) begin
         s.code = code_scaler_pkg::CODE_OVF;
      end else if (s.q > 48'(s.hi)) begin
         s.code = code_scaler_pkg::CODE_OVF;
         s.ovf = 1'b1;
      end else if (s.q < 48'(s.lo)) begin
         s.code = code_scaler_pkg::CODE_UNF;
         s.unf = 1'b1;
      end else begin
         s.code = s.q[15:0]; // Two's complement, sign in bit 15
      end
   end
endmodule
`default_nettype wire

// File: hw/code_scaler_core.sv
// Linear scaling of a raw sample per range, with region limits
`timescale 1ns/10ps
`default_nettype none
module code_scaler_core (
   scale_if.scl_mp s
);
   logic signed [47:0] raw_w;

   // Products stay within 48 bits; signed division truncates toward zero
   always_comb begin
      raw_w = $signed({{16{s.raw[31]}}, s.raw});
      s.q = '0;
      s.hi = code_scaler_pkg::LIM_HI;
      s.lo = code_scaler_pkg::LIM_LO_BI;
      s.cfg_err = 1'b0;
      unique case (s.rng)
         code_scaler_pkg::RNG_VPM10: begin
            s.q = raw_w * code_scaler_pkg::SCALE / code_scaler_pkg::FS_V;
         end
         code_scaler_pkg::RNG_V010: begin
            s.q = raw_w * code_scaler_pkg::SCALE / code_scaler_pkg::FS_V;
            s.lo = code_scaler_pkg::LIM_LO_UNI;
         end
         code_scaler_pkg::RNG_IPM20: begin
            s.q = raw_w * code_scaler_pkg::SCALE / code_scaler_pkg::FS_I;
         end
         code_scaler_pkg::RNG_I020: begin
            s.q = raw_w * code_scaler_pkg::SCALE / code_scaler_pkg::FS_I;
            s.lo = code_scaler_pkg::LIM_LO_UNI;
         end
         code_scaler_pkg::RNG_I420: begin
            // Offset removed before scaling the 16 mA span
            s.q = (raw_w - code_scaler_pkg::OFS_4MA) * code_scaler_pkg::SCALE
                  / code_scaler_pkg::SPAN_16MA;
            s.lo = code_scaler_pkg::LIM_LO_UNI;
         end
         code_scaler_pkg::RNG_R600: begin
            s.q = raw_w * code_scaler_pkg::SCALE / code_scaler_pkg::FS_R;
            s.lo = code_scaler_pkg::LIM_LO_R;
         end
         code_scaler_pkg::RNG_PT100: begin
            // One code step is 0.1 of the chosen unit
            unique case (s.unit)
               code_scaler_pkg::UNIT_C: begin
                  s.q = raw_w / code_scaler_pkg::DIV_C;
                  s.hi = code_scaler_pkg::PT_HI_C;
                  s.lo = code_scaler_pkg::PT_LO_C;
               end
               code_scaler_pkg::UNIT_F: begin
                  s.q = (raw_w * code_scaler_pkg::F_MUL + code_scaler_pkg::F_OFS)
                        / code_scaler_pkg::DIV_F;
                  s.hi = code_scaler_pkg::PT_HI_F;
                  s.lo = code_scaler_pkg::PT_LO_F;
               end
               code_scaler_pkg::UNIT_K: begin
                  s.q = (raw_w + code_scaler_pkg::K_OFS) / code_scaler_pkg::DIV_C;
                  s.hi = code_scaler_pkg::PT_HI_K;
                  s.lo = code_scaler_pkg::PT_LO_K;
               end
               default: begin
                  s.cfg_err = 1'b1;
               end
            endcase
         end
         default: begin
            s.cfg_err = 1'b1; // Deactivated or unknown range
         end
      endcase
   end
endmodule
`default_nettype wire

// File: hw/code_scaler_pkg.sv
// Shared constants for the analog measurement code scaler
`default_nettype none
package code_scaler_pkg;

   // Channel count and register map (byte addresses)
   localparam int unsigned N_CH = 5;
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_RES = 8'h20;
   localparam logic [7:0] OFS_STS = 8'h40;
   localparam logic [7:0] OFS_MSK = 8'h44;

   // Config field layout: range in [3:0], unit in [5:4]
   localparam int unsigned CFG_W = 6;
   localparam int unsigned CFG_RNG_LSB = 0;
   localparam int unsigned CFG_UNIT_LSB = 4;

   // Status / mask bit positions
   localparam int unsigned EVT_W = 4;
   localparam int unsigned EVT_NEW = 0;
   localparam int unsigned EVT_OVF = 1;
   localparam int unsigned EVT_UNF = 2;
   localparam int unsigned EVT_CFG = 3;

   // Measuring range codes
   localparam logic [3:0] RNG_OFF = 4'h0;
   localparam logic [3:0] RNG_I020 = 4'h2;
   localparam logic [3:0] RNG_I420 = 4'h3;
   localparam logic [3:0] RNG_IPM20 = 4'h4;
   localparam logic [3:0] RNG_R600 = 4'h5;
   localparam logic [3:0] RNG_PT100 = 4'h6;
   localparam logic [3:0] RNG_V010 = 4'h8;
   localparam logic [3:0] RNG_VPM10 = 4'h9;

   // Temperature unit codes
   localparam logic [1:0] UNIT_C = 2'h0;
   localparam logic [1:0] UNIT_F = 2'h1;
   localparam logic [1:0] UNIT_K = 2'h2;

   // Reset values of the config and result registers
   localparam logic [5:0] CFG_RST_AI = 6'h09;
   localparam logic [5:0] CFG_RST_PT = 6'h06;
   localparam logic [15:0] RES_RST = 16'h0000;

   // Scaling: raw in uV, nA, mOhm or 0.01 degC
   localparam logic signed [47:0] SCALE = 48'h0000_0000_6c00;
   localparam logic signed [47:0] FS_V = 48'h0000_0098_9680;
   localparam logic signed [47:0] FS_I = 48'h0000_0131_2d00;
   localparam logic signed [47:0] OFS_4MA = 48'h0000_003d_0900;
   localparam logic signed [47:0] SPAN_16MA = 48'h0000_00f4_2400;
   localparam logic signed [47:0] FS_R = 48'h0000_0009_27c0;
   localparam logic signed [47:0] DIV_C = 48'h0000_0000_000a;
   localparam logic signed [47:0] K_OFS = 48'h0000_0000_6ab8;
   localparam logic signed [47:0] F_MUL = 48'h0000_0000_0012;
   localparam logic signed [47:0] F_OFS = 48'h0000_0000_7d00;
   localparam logic signed [47:0] DIV_F = 48'h0000_0000_0064;

   // Result codes and region limits
   localparam logic signed [15:0] CODE_OVF = 16'sh7fff;
   localparam logic signed [15:0] CODE_UNF = 16'sh8000;
   localparam logic signed [15:0] LIM_HI = 16'sh7eff;
   localparam logic signed [15:0] LIM_LO_BI = 16'sh8100;
   localparam logic signed [15:0] LIM_LO_UNI = 16'shed00;
   localparam logic signed [15:0] LIM_LO_R = 16'sh0000;
   localparam logic signed [15:0] PT_HI_C = 16'sh2710;
   localparam logic signed [15:0] PT_LO_C = 16'shf682;
   localparam logic signed [15:0] PT_HI_F = 16'sh4790;
   localparam logic signed [15:0] PT_LO_F = 16'shf02a;
   localparam logic signed [15:0] PT_HI_K = 16'sh31bc;
   localparam logic signed [15:0] PT_LO_K = 16'sh012e;

endpackage
`default_nettype wire

// File: hw/scale_if.sv
// Bundle between the sample path, the scaler and the limiter
`timescale 1ns/10ps
`default_nettype none
interface scale_if;
   logic [31:0] raw;
   logic [3:0] rng;
   logic [1:0] unit;
   logic signed [47:0] q;
   logic signed [15:0] hi;
   logic signed [15:0] lo;
   logic cfg_err;
   logic signed [15:0] code;
   logic ovf;
   logic unf;

   modport top_mp (output raw, rng, unit, input code, ovf, unf, cfg_err);
   modport scl_mp (input raw, rng, unit, output q, hi, lo, cfg_err);
   modport lim_mp (input q, hi, lo, cfg_err, output code, ovf, unf);
endinterface
`default_nettype wire

// File: test/code_scaler_props.sv
// Concurrent checks on the code scaler's top-level ports
`timescale 1ns/10ps
`default_nettype none
module code_scaler_props (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_smp_valid,
   input wire logic [2:0] i_smp_chan,
   input wire logic [31:0] i_smp_raw,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic [31:0] o_hrdata,
   input wire logic o_code_valid,
   input wire logic [2:0] o_code_chan,
   input wire logic [15:0] o_code,
   input wire logic o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   logic take_wr;
   logic take_rd;
   // Address phases taken; data lands one edge later
   assign take_wr = i_hsel & i_htrans[1] & i_hwrite;
   assign take_rd = i_hsel & i_htrans[1] & ~i_hwrite;

   a_result_follows: assert property (i_smp_valid && i_smp_chan <= 3'h4 |=>
      o_code_valid && o_code_chan == $past(i_smp_chan)) else $error("missing result");
   a_bad_chan: assert property (i_smp_valid && i_smp_chan > 3'h4 |=> !o_code_valid)
      else $error("result for unused channel");
   a_pulse_cause: assert property (o_code_valid |-> $past(i_smp_valid))
      else $error("result without sample");
   a_code_holds: assert property (!o_code_valid |-> $stable(o_code))
      else $error("code changed without sample");
   a_top_sat: assert property (i_smp_valid && i_smp_chan <= 3'h4
      && i_smp_raw == 32'h7fff_ffff |=> o_code == 16'h7fff) else $error("no overflow code");
   a_floor_sat: assert property (i_smp_valid && i_smp_chan <= 3'h4
      && i_smp_raw == 32'h8000_0000 |=> o_code inside {16'h8000, 16'h7fff})
      else $error("no underflow code");
   a_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus not ready or error");
   a_irq_rise: assert property ($rose(o_irq) |-> $past(i_smp_valid) || $past(take_wr, 2))
      else $error("interrupt rose without cause");
   a_irq_fall: assert property ($fell(o_irq) |-> $past(take_wr, 2))
      else $error("interrupt fell without write");
   a_rdata_hold: assert property (!$past(take_rd) |-> $stable(o_hrdata))
      else $error("read data moved without read");

   // Main scenarios reached
   c_overflow: cover property (o_code_valid && o_code == 16'h7fff);
   c_underflow: cover property (o_code_valid && o_code == 16'h8000);
   c_irq: cover property ($rose(o_irq));
endmodule

bind analog_measurement_code_scaler code_scaler_props u_props (
   .i_sys_clk, .i_rst_b, .i_hsel, .i_htrans, .i_hwrite, .i_smp_valid, .i_smp_chan,
   .i_smp_raw, .o_hreadyout, .o_hresp, .o_hrdata, .o_code_valid, .o_code_chan,
   .o_code, .o_irq
);
`default_nettype wire

// File: test/process_reader.sv
// Controller side that fetches each new process word
`timescale 1ns/10ps
`default_nettype none
module process_reader (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_code_valid,
   input wire logic [15:0] i_code,
   output logic [15:0] o_word
);
   // Only a flagged word is taken; a held word is never read twice as new
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_word <= 16'h0000;
      end else if (i_code_valid) begin
         o_word <= i_code;
      end
   end
endmodule
`default_nettype wire

// File: test/test_analog_measurement_code_scaler.sv
// Self-checking bench for the analog measurement code scaler
`timescale 1ns/10ps
`default_nettype none
module test_analog_measurement_code_scaler;
   localparam logic [31:0] A_CFG0 = 32'(code_scaler_pkg::OFS_CFG);
   localparam logic [31:0] A_CFG1 = A_CFG0 + 32'h0000_0004;
   localparam logic [31:0] A_RES1 = 32'(code_scaler_pkg::OFS_RES) + 32'h0000_0004;
   localparam logic [31:0] A_STS = 32'(code_scaler_pkg::OFS_STS);
   localparam logic [31:0] A_MSK = 32'(code_scaler_pkg::OFS_MSK);
   logic i_sys_clk, i_rst_b, i_hsel, i_hwrite, i_smp_valid;
   logic [31:0] i_haddr, i_hwdata, i_smp_raw, o_hrdata;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize, i_smp_chan, o_code_chan;
   logic o_hreadyout, o_hresp, o_code_valid, o_irq;
   logic [15:0] o_code, rd_word;
   int failures, tests_run, cycles;

   analog_measurement_code_scaler dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
      .i_smp_valid(i_smp_valid), .i_smp_chan(i_smp_chan), .i_smp_raw(i_smp_raw),
      .o_code_valid(o_code_valid), .o_code_chan(o_code_chan), .o_code(o_code),
      .o_irq(o_irq));
   process_reader reader_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_code_valid(o_code_valid), .i_code(o_code), .o_word(rd_word));

   // 250 MHz clock
   always #2 i_sys_clk = ~i_sys_clk;

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles needed
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One AHB-Lite single transfer; data phase waits for hready, no fixed latency
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_hwrite <= wr;
      i_htrans <= 2'h2;
      do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(o_hrdata, exp);
      chk(32'(o_hresp), 32'h0000_0000);
   endtask

   // Sample in, one-cycle flag next edge, reader holds the word after
   task automatic smp(input logic [2:0] ch, input int raw, input logic [15:0] exp);
      @(posedge i_sys_clk);
      i_smp_valid <= 1'b1;
      i_smp_chan <= ch;
      i_smp_raw <= raw;
      @(posedge i_sys_clk);
      i_smp_valid <= 1'b0;
      #1;
      chk(32'(o_code_valid), 32'h0000_0001);
      chk(32'(o_code_chan), 32'(ch));
      @(posedge i_sys_clk);
      #1;
      chk(32'(o_code_valid), 32'h0000_0000);
      chk(32'(rd_word), 32'(exp));
   endtask

   task automatic sc(input logic [5:0] cfg, input int raw, input logic [15:0] exp);
      wr(A_CFG1, 32'(cfg));
      smp(3'h1, raw, exp);
   endtask

   initial begin
      i_sys_clk = 1'b0;
      i_rst_b = 1'b0;
      {i_hsel, i_hwrite, i_smp_valid, i_htrans, i_smp_chan} = '0;
      {i_haddr, i_hwdata, i_smp_raw} = '0;
      i_hsize = 3'h2;
      repeat (2) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      rdc(A_CFG0, 32'h0000_0009);
      rdc(A_CFG0 + 32'h0000_0010, 32'h0000_0006);
      rdc(A_RES1, 32'h0000_0000);
      rdc(A_MSK, 32'h0000_0000);
      smp(3'h4, 85000, 16'h2134);
      sc(6'h09, 10000000, 16'h6c00);
      sc(6'h09, -10000000, 16'h9400);
      sc(6'h09, 5000000, 16'h3600);
      sc(6'h09, 11758898, 16'h7eff);
      sc(6'h09, 11759260, 16'h7fff);
      sc(6'h09, -11759260, 16'h8100);
      sc(6'h09, -1, 16'h0000);
      sc(6'h09, 32'sh8000_0000, 16'h8000);
      sc(6'h08, -1759260, 16'hed00);
      sc(6'h08, -1759621, 16'h8000);
      sc(6'h04, 20000000, 16'h6c00);
      sc(6'h04, -20000000, 16'h9400);
      sc(6'h04, 24000000, 16'h7fff);
      sc(6'h02, 10000000, 16'h3600);
      sc(6'h02, -3518519, 16'hed00);
      sc(6'h02, -3520000, 16'h8000);
      sc(6'h03, 12000000, 16'h3600);
      sc(6'h03, 4000000, 16'h0000);
      sc(6'h03, 1185000, 16'hed00);
      sc(6'h03, 1184000, 16'h8000);
      sc(6'h03, 22810000, 16'h7ef7);
      sc(6'h03, 22820000, 16'h7fff);
      sc(6'h05, 600000, 16'h6c00);
      sc(6'h05, 705530, 16'h7efe);
      sc(6'h05, 706000, 16'h7fff);
      sc(6'h05, -100, 16'h8000);
      sc(6'h06, 100000, 16'h2710);
      sc(6'h06, 100010, 16'h7fff);
      sc(6'h06, -24300, 16'hf682);
      sc(6'h06, -24310, 16'h8000);
      sc(6'h06, -20000, 16'hf830);
      sc(6'h16, 100000, 16'h4790);
      sc(6'h16, -24300, 16'hf02a);
      sc(6'h16, 100010, 16'h7fff);
      sc(6'h16, -24400, 16'h8000);
      sc(6'h16, 32'sh7fff_ffff, 16'h7fff);
      sc(6'h26, 100000, 16'h31bc);
      sc(6'h26, -24300, 16'h012e);
      sc(6'h26, -24310, 16'h8000);
      sc(6'h36, 100000, 16'h7fff);
      sc(6'h00, 0, 16'h7fff);
      sc(6'h07, 0, 16'h7fff);
      // Unused channel must stay silent
      @(posedge i_sys_clk);
      i_smp_valid <= 1'b1;
      i_smp_chan <= 3'h5;
      @(posedge i_sys_clk);
      i_smp_valid <= 1'b0;
      #1;
      chk(32'(o_code_valid), 32'h0000_0000);
      // Result store is read-only; unmapped space reads zero
      wr(A_RES1, 32'h0000_1234);
      rdc(A_RES1, 32'h0000_7fff);
      rdc(32'h0000_0080, 32'h0000_0000);
      rdc(32'h0000_0104, 32'h0000_0000);
      // Sticky status, mask and level interrupt
      wr(A_STS, 32'h0000_000f);
      rdc(A_STS, 32'h0000_0000);
      smp(3'h0, 20000000, 16'h7fff);
      rdc(A_STS, 32'h0000_0003);
      chk(32'(o_irq), 32'h0000_0000);
      wr(A_MSK, 32'h0000_0002);
      #1;
      chk(32'(o_irq), 32'h0000_0001);
      wr(A_STS, 32'h0000_0002);
      #1;
      chk(32'(o_irq), 32'h0000_0000);
      rdc(A_STS, 32'h0000_0001);
      // Config error and underflow events, then unmask underflow
      smp(3'h1, 0, 16'h7fff);
      sc(6'h08, -2000000, 16'h8000);
      rdc(A_STS, 32'h0000_000d);
      chk(32'(o_irq), 32'h0000_0000);
      wr(A_MSK, 32'h0000_0004);
      #1;
      chk(32'(o_irq), 32'h0000_0001);
      conclude();
   end
endmodule
`default_nettype wire
